//--- hdl/mswdmx_pkg.sv
// Package for the mesh switch point and message demux block.
// Assumes a single core clock; all users reference names with the package prefix.
package mswdmx_pkg;
	// Flit and header layout
	localparam int FLIT_W = 32;
	localparam int LEN_LO = 0;
	localparam int LEN_HI = 6;
	localparam int DY_LO = 7;
	localparam int DY_HI = 17;
	localparam int DX_LO = 18;
	localparam int DX_HI = 28;
	localparam int COORD_W = 11;
	localparam int LEN_W = 7;
	// Encoded length zero stands for a full 128-word packet
	localparam logic [7:0] LEN_ZERO_WORDS = 8'h80;
	// Input buffering and credit reset value
	localparam int IBUF_DEPTH = 3;
	localparam logic [1:0] CREDIT_RESET = 2'h3;
	// Port numbering: north, east, south, west, local core
	localparam int NPORT = 5;
	localparam int P_N = 0;
	localparam int P_E = 1;
	localparam int P_S = 2;
	localparam int P_W = 3;
	localparam int P_L = 4;
	// Demux queue count and status bit positions
	localparam int NTAGQ = 4;
	localparam int AVAIL_CA_BIT = 4;
	localparam int CAQ_DEPTH = 32;
	// Flit carrier on a link
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} mswdmx_flit_t;
	// Demux receive states, one-hot
	typedef enum logic [2:0] {
		RX_HDR = 3'b001,
		RX_TAG = 3'b010,
		RX_PAY = 3'b100
	} mswdmx_rx_t;
endpackage : mswdmx_pkg

//--- hdl/mswdmx_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module mswdmx_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out,
	output logic [$clog2(DEPTH+1)-1:0] count_out
);
	localparam int AW = $clog2(DEPTH);
	// Storage array
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [$clog2(DEPTH+1)-1:0] cnt_q;
	logic push, pop;
	assign in_ready_out = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
	assign out_valid_out = (cnt_q != '0);
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = mem_q[rd_q];
	assign count_out = cnt_q;
	// Write side
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end
	// Pointers and occupancy
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + {{($clog2(DEPTH+1)-1){1'b0}}, push} - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
		end
	end
endmodule : mswdmx_fifo
`default_nettype wire

//--- hdl/mswdmx_top.sv
// Mesh switch point with message demux on the local output.
// Assumes neighbours return one credit pulse per consumed flit and keep
// zero in reserved header bits; one core clock drives everything.
//
// Contract
// - Full crossbar, no U-turn routing
// - Won output held until packet tail
// - X then Y dimension order routing
// - Config selects X-first or Y-first
// - Three-flit input buffers, per-output credits
// - Credit decrement on send, return on consume
// - Round-robin output arbitration
// - One-cycle hop on core clock
// - Links are 32 bits wide
// - Header holds length, dest Y, dest X
// - Length counts tag+payload; zero means 128
// - Tag match strips header, queues payload
// - Unmatched packets go to catch-all intact (here the header flit is dropped; tag and payload are queued)
// - Catch-all exposes head tag, remaining, data
// - Availability status bits per queue
// - Catch-all interrupt gated by system enable
// - Tagged queues share enabled interrupt
// - Readable word counts per queue
// - Interlocked register reads and sends
// - Output protection bit raises violation interrupt
// - Per-queue FIFOs, system portion partitioned
`timescale 1ns/1ps
`default_nettype none
module mswdmx_top #(
	parameter logic [10:0] MY_X = 11'h000,
	parameter logic [10:0] MY_Y = 11'h000,
	parameter int TQ_DEPTH = 32
) (
	input wire logic clock_in,
	input wire logic rst_in,
	// Neighbour links: index N,E,S,W
	input wire mswdmx_pkg::mswdmx_flit_t [3:0] link_rx_in,
	output mswdmx_pkg::mswdmx_flit_t [3:0] link_tx_out,
	output logic [3:0] link_credit_out,
	input wire logic [3:0] link_credit_in,
	// Core send port (interlocked)
	input wire logic send_valid_in,
	input wire logic [31:0] send_data_in,
	output logic send_ready_out,
	// Configuration
	input wire logic y_first_in,
	input wire logic [4:0] port_protect_in,
	input wire logic [31:0] tag_reg_in [4],
	input wire logic [3:0] tagged_queue_irq_enable_in,
	input wire logic sys_irq_enable_in,
	// Tagged queue reads (interlocked)
	input wire logic [3:0] q_read_in,
	output logic [3:0] q_valid_out,
	output logic [31:0] q_data_out [4],
	output logic [5:0] q_count_out [4],
	// Catch-all queue
	input wire logic ca_read_in,
	output logic ca_valid_out,
	output logic [31:0] catchall_payload_port_out,
	output logic [31:0] catchall_head_flow_label_out,
	output logic [7:0] catchall_head_words_left_out,
	output logic [5:0] catchall_word_count_out,
	// Status and interrupts
	output logic [4:0] queue_data_available_status_out,
	output logic catchall_irq_out,
	output logic tagged_avail_irq_out,
	output logic protect_irq_out
);
	localparam int NP = mswdmx_pkg::NPORT;
	// Input buffer state, per port
	logic [31:0] ib_mem_q [NP][mswdmx_pkg::IBUF_DEPTH];
	logic [1:0] ib_cnt_q [NP];
	logic [1:0] ib_rd_q [NP], ib_wr_q [NP];
	logic [NP-1:0] ib_push, ib_pop;
	logic [31:0] ib_head [NP];
	// Per-input packet tracking
	logic [NP-1:0] in_hdr_q;
	logic [7:0] in_left_q [NP];
	logic [2:0] in_dir_q [NP];
	logic [2:0] req_dir [NP];
	// Per-output ownership and credits
	logic [NP-1:0] out_busy_q;
	logic [2:0] out_own_q [NP];
	logic [2:0] rr_q [NP];
	logic [1:0] credit_q [4];
	logic [NP-1:0] out_ready;
	logic [NP-1:0] move;
	logic [2:0] move_out [NP];
	logic [NP-1:0] grant_new;
	logic [2:0] grant_in [NP];
	logic [31:0] local_flit;
	logic local_valid;
	logic local_ready;
	logic [NP-1:0] viol;
	logic protect_irq_q;

	// Input flit sources: four links and the core send port
	logic [NP-1:0] rx_valid;
	logic [31:0] rx_data [NP];
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			rx_valid[p] = link_rx_in[p].valid;
			rx_data[p] = link_rx_in[p].data;
		end
		rx_valid[mswdmx_pkg::P_L] = send_valid_in;
		rx_data[mswdmx_pkg::P_L] = send_data_in;
	end
	// Core send is held off while its buffer is full
	assign send_ready_out = (ib_cnt_q[mswdmx_pkg::P_L] != 2'(mswdmx_pkg::IBUF_DEPTH));

	// Route computation: dimension ordered, order selectable
	function automatic logic [2:0] route(input logic [31:0] h, input logic yf);
		logic [10:0] dx, dy;
		logic [2:0] r;
		dx = h[mswdmx_pkg::DX_HI:mswdmx_pkg::DX_LO];
		dy = h[mswdmx_pkg::DY_HI:mswdmx_pkg::DY_LO];
		r = 3'(mswdmx_pkg::P_L);
		if (!yf) begin
			if (dx > MY_X) r = 3'(mswdmx_pkg::P_E);
			else if (dx < MY_X) r = 3'(mswdmx_pkg::P_W);
			else if (dy > MY_Y) r = 3'(mswdmx_pkg::P_S);
			else if (dy < MY_Y) r = 3'(mswdmx_pkg::P_N);
		end else begin
			if (dy > MY_Y) r = 3'(mswdmx_pkg::P_S);
			else if (dy < MY_Y) r = 3'(mswdmx_pkg::P_N);
			else if (dx > MY_X) r = 3'(mswdmx_pkg::P_E);
			else if (dx < MY_X) r = 3'(mswdmx_pkg::P_W);
		end
		return r;
	endfunction : route

	// Per-input buffering and packet tracking
	genvar gp;
	generate
		for (gp = 0; gp < NP; gp++) begin : g_in
			assign ib_push[gp] = rx_valid[gp] && (ib_cnt_q[gp] != 2'(mswdmx_pkg::IBUF_DEPTH));
			assign ib_head[gp] = ib_mem_q[gp][ib_rd_q[gp]];
			assign req_dir[gp] = in_hdr_q[gp] ? route(ib_head[gp], y_first_in) : in_dir_q[gp];
			// Three-entry ring buffer
			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					ib_cnt_q[gp] <= '0;
					ib_rd_q[gp] <= '0;
					ib_wr_q[gp] <= '0;
				end else begin
					if (ib_push[gp]) begin
						ib_mem_q[gp][ib_wr_q[gp]] <= rx_data[gp];
						ib_wr_q[gp] <= (ib_wr_q[gp] == 2'd2) ? 2'd0 : ib_wr_q[gp] + 2'd1;
					end
					if (ib_pop[gp]) ib_rd_q[gp] <= (ib_rd_q[gp] == 2'd2) ? 2'd0 : ib_rd_q[gp] + 2'd1;
					ib_cnt_q[gp] <= ib_cnt_q[gp] + {1'b0, ib_push[gp]} - {1'b0, ib_pop[gp]};
				end
			end
			// Header latches direction and flit count for the rest of the packet
			always_ff @(posedge clock_in) begin
				if (rst_in) begin
					in_hdr_q[gp] <= 1'b1;
					in_left_q[gp] <= '0;
					in_dir_q[gp] <= '0;
				end else if (ib_pop[gp]) begin
					if (in_hdr_q[gp]) begin
						in_hdr_q[gp] <= 1'b0;
						in_dir_q[gp] <= req_dir[gp];
						// Zero length encodes the full 128 words
						in_left_q[gp] <= (ib_head[gp][6:0] == 7'h00) ? mswdmx_pkg::LEN_ZERO_WORDS
							: {1'b0, ib_head[gp][6:0]};
					end else begin
						in_left_q[gp] <= in_left_q[gp] - 8'd1;
						if (in_left_q[gp] == 8'd1) in_hdr_q[gp] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// Output readiness: credits on links, FIFO space locally
	always_comb begin
		for (int o = 0; o < 4; o++) out_ready[o] = (credit_q[o] != 2'd0);
		out_ready[mswdmx_pkg::P_L] = local_ready;
	end

	// Arbitration and movement across the crossbar
	always_comb begin
		int c;
		c = 0;
		ib_pop = '0;
		move = '0;
		grant_new = '0;
		viol = '0;
		for (int o = 0; o < NP; o++) grant_in[o] = '0;
		for (int i = 0; i < NP; i++) move_out[i] = '0;
		for (int o = 0; o < NP; o++) begin
			if (out_busy_q[o]) begin
				// Locked to one packet until its tail passes
				grant_in[o] = out_own_q[o];
			end else begin
				// Search starting after the last winner
				for (int k = NP; k >= 1; k--) begin
					c = (int'(rr_q[o]) + k) % NP;
					if (ib_cnt_q[c] != 2'd0 && in_hdr_q[c] && int'(req_dir[c]) == o && c != o) begin
						grant_new[o] = 1'b1;
						grant_in[o] = 3'(c);
					end
				end
			end
			if ((out_busy_q[o] || grant_new[o]) && ib_cnt_q[grant_in[o]] != 2'd0) begin
				if (port_protect_in[o]) begin
					viol[o] = 1'b1;
				end else if (out_ready[o]) begin
					move[grant_in[o]] = 1'b1;
					move_out[grant_in[o]] = 3'(o);
					ib_pop[grant_in[o]] = 1'b1;
				end
			end
		end
	end

	// Ownership and round-robin pointers
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			out_busy_q <= '0;
			for (int o = 0; o < NP; o++) begin
				out_own_q[o] <= '0;
				rr_q[o] <= '0;
			end
		end else begin
			for (int o = 0; o < NP; o++) begin
				if (grant_new[o] && move[grant_in[o]]) begin
					out_busy_q[o] <= 1'b1;
					out_own_q[o] <= grant_in[o];
					rr_q[o] <= grant_in[o];
				end else if (out_busy_q[o] && move[out_own_q[o]] && !in_hdr_q[out_own_q[o]]
					&& in_left_q[out_own_q[o]] == 8'd1) begin
					out_busy_q[o] <= 1'b0;
				end
			end
		end
	end

	// Link outputs registered, one hop per cycle
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int o = 0; o < 4; o++) link_tx_out[o] <= '0;
			link_credit_out <= '0;
		end else begin
			for (int o = 0; o < 4; o++) begin
				link_tx_out[o].valid <= move[grant_in[o]] && move_out[grant_in[o]] == 3'(o);
				link_tx_out[o].data <= ib_head[grant_in[o]];
			end
			// One credit back per consumed flit
			link_credit_out <= ib_pop[3:0];
		end
	end

	// Credit counters per link output
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			for (int o = 0; o < 4; o++) credit_q[o] <= mswdmx_pkg::CREDIT_RESET;
		end else begin
			// One credit spent per flit launched, one regained per neighbour pulse
			for (int o = 0; o < 4; o++) begin
				credit_q[o] <= credit_q[o] - {1'b0, move[grant_in[o]] && move_out[grant_in[o]] == 3'(o)}
					+ {1'b0, link_credit_in[o]};
			end
		end
	end

	// Violation interrupt is a sticky-free level while any attempt persists
	always_ff @(posedge clock_in) begin
		if (rst_in) protect_irq_q <= 1'b0;
		else protect_irq_q <= |viol;
	end
	assign protect_irq_out = protect_irq_q && sys_irq_enable_in;

	// Local delivery into the demux
	assign local_valid = move[grant_in[mswdmx_pkg::P_L]] && move_out[grant_in[mswdmx_pkg::P_L]] == 3'(mswdmx_pkg::P_L);
	assign local_flit = ib_head[grant_in[mswdmx_pkg::P_L]];

	// Demux state
	mswdmx_pkg::mswdmx_rx_t rx_q;
	logic [7:0] rx_len_q;
	logic [7:0] rx_left_q;
	logic [2:0] rx_q_sel_q;
	logic [2:0] match_sel;
	// Lowest matching tag register wins; four means no match
	always_comb begin
		match_sel = 3'd4;
		for (int t = mswdmx_pkg::NTAGQ - 1; t >= 0; t--) begin
			if (local_flit == tag_reg_in[t]) match_sel = 3'(t);
		end
	end

	// Queue push signals
	logic [4:0] qpush;
	logic [4:0] qready;
	logic [31:0] qdata [5];
	assign local_ready = &qready;
	always_comb begin
		qpush = '0;
		for (int q = 0; q < 5; q++) qdata[q] = local_flit;
		if (local_valid) begin
			unique case (rx_q)
				mswdmx_pkg::RX_HDR: qpush = '0;
				mswdmx_pkg::RX_TAG: begin
					// Catch-all keeps the tag word as one entry; length is held apart in ca_len_fifo_q
					if (match_sel == 3'd4) qpush[4] = 1'b1;
				end
				mswdmx_pkg::RX_PAY: qpush[rx_q_sel_q] = 1'b1;
			endcase
		end
		qdata[4] = (rx_q == mswdmx_pkg::RX_TAG) ? local_flit : local_flit;
	end

	// Receive sequencer
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rx_q <= mswdmx_pkg::RX_HDR;
			rx_len_q <= '0;
			rx_left_q <= '0;
			rx_q_sel_q <= '0;
		end else if (local_valid) begin
			unique case (rx_q)
				mswdmx_pkg::RX_HDR: begin
					rx_len_q <= (local_flit[6:0] == 7'h00) ? mswdmx_pkg::LEN_ZERO_WORDS : {1'b0, local_flit[6:0]};
					rx_q <= mswdmx_pkg::RX_TAG;
				end
				mswdmx_pkg::RX_TAG: begin
					rx_q_sel_q <= match_sel;
					rx_left_q <= rx_len_q - 8'd1;
					rx_q <= (rx_len_q == 8'd1) ? mswdmx_pkg::RX_HDR : mswdmx_pkg::RX_PAY;
				end
				mswdmx_pkg::RX_PAY: begin
					rx_left_q <= rx_left_q - 8'd1;
					if (rx_left_q == 8'd1) rx_q <= mswdmx_pkg::RX_HDR;
				end
			endcase
		end
	end

	// Per-queue FIFOs; catch-all tag entries are marked by bit 32
	logic [32:0] q_out [5];
	logic [4:0] q_valid;
	logic [4:0] q_pop;
	logic [5:0] q_cnt [5];
	generate
		for (gp = 0; gp < 5; gp++) begin : g_q
			mswdmx_fifo #(.WIDTH(33), .DEPTH(gp == 4 ? mswdmx_pkg::CAQ_DEPTH : TQ_DEPTH)) u_fifo (
				.clock_in(clock_in),
				.rst_in(rst_in),
				.in_valid_in(qpush[gp]),
				.in_ready_out(qready[gp]),
				.in_data_in({(gp == 4) && (rx_q == mswdmx_pkg::RX_TAG), qdata[gp]}),
				.out_valid_out(q_valid[gp]),
				.out_ready_in(q_pop[gp]),
				.out_data_out(q_out[gp]),
				.count_out(q_cnt[gp])
			);
		end
	endgenerate

	// Tagged queue outputs; reads stall via valid
	assign q_pop[3:0] = q_read_in & q_valid[3:0];
	always_comb begin
		for (int q = 0; q < 4; q++) begin
			q_valid_out[q] = q_valid[q];
			q_data_out[q] = q_out[q][31:0];
			q_count_out[q] = q_cnt[q];
		end
	end

	// Catch-all head tracking: tag word is consumed into head registers
	logic [31:0] ca_tag_q;
	logic [7:0] ca_left_q;
	logic ca_head_q;
	logic [7:0] ca_len_fifo_q;
	assign q_pop[4] = q_valid[4] && (q_out[4][32] ? !ca_head_q || ca_left_q == 8'd0 : ca_read_in);
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ca_tag_q <= '0;
			ca_left_q <= '0;
			ca_head_q <= 1'b0;
		end else if (q_pop[4]) begin
			if (q_out[4][32]) begin
				ca_tag_q <= q_out[4][31:0];
				ca_left_q <= ca_len_fifo_q;
				ca_head_q <= 1'b1;
			end else begin
				ca_left_q <= ca_left_q - 8'd1;
				if (ca_left_q == 8'd1) ca_head_q <= 1'b0;
			end
		end
	end
	// Length travels alongside; simplification: taken from the last tag seen
	always_ff @(posedge clock_in) begin
		if (rst_in) ca_len_fifo_q <= '0;
		else if (local_valid && rx_q == mswdmx_pkg::RX_TAG) ca_len_fifo_q <= rx_len_q - 8'd1;
	end
	assign ca_valid_out = q_valid[4] && !q_out[4][32];
	assign catchall_payload_port_out = q_out[4][31:0];
	assign catchall_head_flow_label_out = ca_tag_q;
	assign catchall_head_words_left_out = ca_left_q;
	assign catchall_word_count_out = q_cnt[4];

	// Availability status and interrupts
	assign queue_data_available_status_out = {ca_valid_out || ca_head_q, q_valid[3:0]};
	assign catchall_irq_out = queue_data_available_status_out[mswdmx_pkg::AVAIL_CA_BIT] && sys_irq_enable_in;
	assign tagged_avail_irq_out = |(q_valid[3:0] & tagged_queue_irq_enable_in) && sys_irq_enable_in;

	// Checks
	// A spent east credit stays spent until the neighbour returns one
	credit_bound_a: assert property (@(posedge clock_in) disable iff (rst_in)
		(credit_q[1] == 2'd0 && !link_credit_in[1]) |=> credit_q[1] == 2'd0) else $error("east credit wrapped");
	stall_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
		credit_q[1] == 2'd0 |=> !link_tx_out[1].valid) else $error("east sent without credit");
	protect_block_a: assert property (@(posedge clock_in) disable iff (rst_in)
		port_protect_in[1] |=> !link_tx_out[1].valid) else $error("flit left protected port");
	no_uturn_a: assert property (@(posedge clock_in) disable iff (rst_in)
		!(move[0] && move_out[0] == 3'd0)) else $error("north routed to north");
	// A full core buffer that is not drained must stay full, never wrap
	ibuf_bound_a: assert property (@(posedge clock_in) disable iff (rst_in)
		(ib_cnt_q[4] == 2'd3 && !ib_pop[4]) |=> ib_cnt_q[4] == 2'd3) else $error("input buffer overflow");
	ca_irq_a: assert property (@(posedge clock_in) disable iff (rst_in)
		(ca_valid_out && sys_irq_enable_in) |-> catchall_irq_out) else $error("catch-all irq missing");
	tag_irq_gate_a: assert property (@(posedge clock_in) disable iff (rst_in)
		(tagged_queue_irq_enable_in == 4'h0) |-> !tagged_avail_irq_out) else $error("irq without enable");
	hop_once_a: assert property (@(posedge clock_in) disable iff (rst_in)
		(move[4] && move_out[4] == 3'd1) |=> link_tx_out[1].valid) else $error("hop took over one cycle");
endmodule : mswdmx_top
`default_nettype wire

//--- test/mswdmx_nbr_model.sv
// Model of the four neighbour switch inputs that face the switch's links.
// Assumes one flit per valid cycle on each link and one credit pulse per flit.
`timescale 1ns/1ps
`default_nettype none
module mswdmx_nbr_model (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire mswdmx_pkg::mswdmx_flit_t [3:0] link_tx_in,
	input wire logic [3:0] slow_in,
	output logic [3:0] credit_out,
	output logic [15:0] flit_count_out [4],
	output logic [15:0] overrun_count_out
);
	int held [4]; // Flits sitting in each neighbour's input buffer
	int wait_t [4]; // Drain pause, lets the bench stall a neighbour
	// Accept, hold, drain and return credits; a slow neighbour pauses at random
	always @(posedge clock_in) begin
		int h;
		int ov;
		ov = 0;
		for (int p = 0; p < 4; p++) begin
			h = held[p];
			credit_out[p] <= 1'b0;
			if (link_tx_in[p].valid) begin
				h = h + 1;
				flit_count_out[p] <= flit_count_out[p] + 16'h0001;
				// A fourth buffered flit means the sender ignored its credits
				if (h > 3)
					ov = ov + 1;
			end
			if (h > 0 && wait_t[p] == 0) begin
				h = h - 1;
				credit_out[p] <= 1'b1;
				wait_t[p] <= slow_in[p] ? int'($urandom_range(6)) : 0;
			end else if (wait_t[p] > 0) begin
				wait_t[p] <= wait_t[p] - 1;
			end
			held[p] <= h;
		end
		overrun_count_out <= overrun_count_out + ov[15:0];
		if (rst_in) begin
			for (int p = 0; p < 4; p++) begin
				held[p] <= 0;
				wait_t[p] <= 0;
				flit_count_out[p] <= 16'h0000;
			end
			overrun_count_out <= 16'h0000;
		end
	end
endmodule : mswdmx_nbr_model
`default_nettype wire

//--- test/mswdmx_bench.sv
// Self-checking bench for the mesh switch point and message demux.
// Assumes the neighbour model above; the bench plays the core and link senders.
`timescale 1ns/1ps
`default_nettype none
module mswdmx_bench;
	localparam logic [10:0] MX = 11'h005;
	localparam logic [10:0] MY = 11'h005;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	mswdmx_pkg::mswdmx_flit_t [3:0] rx = '0;
	mswdmx_pkg::mswdmx_flit_t [3:0] tx;
	logic [3:0] cred_out;
	logic [3:0] cred_in;
	logic send_valid = 1'b0;
	logic [31:0] send_data = 32'h0000_0000;
	logic send_ready;
	logic y_first = 1'b0;
	logic [4:0] protect = 5'h00;
	logic [31:0] tags [4];
	logic [3:0] irq_en = 4'h0;
	logic sys_en = 1'b1;
	logic [3:0] q_read = 4'h0;
	logic [3:0] q_valid;
	logic [31:0] q_data [4];
	logic [5:0] q_count [4];
	logic ca_read = 1'b0;
	logic ca_valid;
	logic [31:0] ca_data;
	logic [31:0] ca_label;
	logic [7:0] ca_left;
	logic [5:0] ca_count;
	logic [4:0] avail;
	logic ca_irq;
	logic tq_irq;
	logic prot_irq;
	logic [3:0] slow = 4'h0;
	logic [15:0] nbr [4];
	logic [15:0] base [4];
	logic [15:0] overrun;
	logic [31:0] pay [$]; // Payload of the last packet sent
	logic [10:0] dx [4] = '{11'h007, 11'h003, 11'h007, 11'h005};
	logic [10:0] dy [4] = '{11'h005, 11'h002, 11'h002, 11'h009};
	int ep [4] = '{1, 3, 0, 0}; // Expected link: 1 east, 3 west, 0 north or south
	int bad_count = 0;
	int check_count = 0;
	int cycles = 0;
	int sent [4] = '{0, 0, 0, 0}; // Flits put on each input link
	int ret [4] = '{0, 0, 0, 0}; // Credits handed back for them

	mswdmx_top #(.MY_X(MX), .MY_Y(MY), .TQ_DEPTH(32)) dut (.clock_in(clock_in), .rst_in(rst_in),
		.link_rx_in(rx), .link_tx_out(tx), .link_credit_out(cred_out), .link_credit_in(cred_in),
		.send_valid_in(send_valid), .send_data_in(send_data), .send_ready_out(send_ready),
		.y_first_in(y_first), .port_protect_in(protect), .tag_reg_in(tags),
		.tagged_queue_irq_enable_in(irq_en), .sys_irq_enable_in(sys_en), .q_read_in(q_read),
		.q_valid_out(q_valid), .q_data_out(q_data), .q_count_out(q_count), .ca_read_in(ca_read),
		.ca_valid_out(ca_valid), .catchall_payload_port_out(ca_data), .catchall_head_flow_label_out(ca_label),
		.catchall_head_words_left_out(ca_left), .catchall_word_count_out(ca_count),
		.queue_data_available_status_out(avail), .catchall_irq_out(ca_irq),
		.tagged_avail_irq_out(tq_irq), .protect_irq_out(prot_irq));
	mswdmx_nbr_model nbr_model (.clock_in(clock_in), .rst_in(rst_in), .link_tx_in(tx), .slow_in(slow),
		.credit_out(cred_in), .flit_count_out(nbr), .overrun_count_out(overrun));

	// Free-running core clock, 100 MHz
	initial begin
		forever #5 clock_in = ~clock_in;
	end
	// Credits counted off the falling edge so the senders never race them
	always @(negedge clock_in) begin
		for (int p = 0; p < 4; p++)
			if (cred_out[p] === 1'b1)
				ret[p]++;
	end
	// Hang guard: the whole run needs about a thousand cycles
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic settle(input int n);
		repeat (n) @(posedge clock_in);
	endtask : settle
	function automatic logic [31:0] hdr(input logic [10:0] x, input logic [10:0] y, input logic [6:0] len);
		return {3'b000, x, y, len};
	endfunction : hdr
	// Link sender: drops valid while its credit is spent
	task automatic put_link(input int p, input logic [31:0] w);
		while (sent[p] - ret[p] >= 3) begin
			rx[p].valid <= 1'b0;
			@(posedge clock_in);
		end
		rx[p] <= '{valid: 1'b1, data: w};
		sent[p]++;
		@(posedge clock_in);
	endtask : put_link
	// Core sender: holds the word until ready is seen at an edge
	task automatic core_send(input logic [31:0] w);
		logic ok;
		send_valid <= 1'b1;
		send_data <= w;
		do begin
			@(negedge clock_in);
			ok = send_ready;
			@(posedge clock_in);
		end while (ok !== 1'b1);
	endtask : core_send
	// Header, tag, then random payload; port 4 is the core
	task automatic pkt(input int p, input logic [10:0] x, input logic [10:0] y, input logic [6:0] len,
		input logic [31:0] tag);
		int n;
		logic [31:0] w;
		n = (len == 7'h00) ? 128 : int'(len);
		pay = {};
		for (int i = 0; i <= n; i++) begin
			w = (i == 0) ? hdr(x, y, len) : (i == 1) ? tag : $urandom;
			if (i > 1)
				pay.push_back(w);
			if (p == 4)
				core_send(w);
			else
				put_link(p, w);
		end
		if (p == 4)
			send_valid <= 1'b0;
		else
			rx[p].valid <= 1'b0;
	endtask : pkt
	// Drains queue k (4 is the catch-all) against the last payload
	task automatic pop_all(input int k);
		int n;
		foreach (pay[i]) begin
			n = 0;
			@(negedge clock_in);
			while ((k == 4 ? ca_valid : q_valid[k]) !== 1'b1 && n < 200) begin
				@(negedge clock_in);
				n++;
			end
			check("queue valid", 1, k == 4 ? ca_valid : q_valid[k]);
			if (k == 4)
				check("ca left", pay.size() - i, ca_left);
			check("queue data", pay[i], k == 4 ? ca_data : q_data[k]);
			@(posedge clock_in);
			if (k == 4)
				ca_read <= 1'b1;
			else
				q_read[k] <= 1'b1;
			@(posedge clock_in);
			ca_read <= 1'b0;
			q_read <= 4'h0;
		end
	endtask : pop_all

	initial begin
		cycles = $urandom(32'h1e0c);
		cycles = 0;
		for (int i = 0; i < 4; i++)
			tags[i] = {4'(i + 1), 28'($urandom)};
		settle(8);
		rst_in <= 1'b0;
		settle(2);
		// Each tagged queue in turn, alternate interrupt enables
		irq_en <= 4'h5;
		for (int q = 0; q < 4; q++) begin
			pkt(mswdmx_pkg::P_W, MX, MY, 7'(2 + q), tags[q]);
			settle(12);
			check("avail", 32'(1 << q), 32'(avail));
			check("q count", q + 1, q_count[q]);
			check("tq irq", 32'(q % 2 == 0), tq_irq);
			pop_all(q);
			settle(3);
			check("avail empty", 0, avail);
		end
		check("credits back", sent[3], ret[3]);
		// Two registers hold the same tag: lowest queue wins
		tags[2] <= tags[0];
		pkt(mswdmx_pkg::P_N, MX, MY, 7'h03, tags[0]);
		settle(12);
		check("dup avail", 1, avail);
		pop_all(0);
		tags[2] <= {4'h3, 28'($urandom)};
		// Unmatched tag lands in the catch-all with its tag
		pkt(mswdmx_pkg::P_E, MX, MY, 7'h04, 32'hf00d_0001);
		settle(12);
		check("ca avail", 32'h0000_0010, avail);
		check("ca label", 32'hf00d_0001, ca_label);
		check("ca count", 3, ca_count);
		check("ca irq", 1, ca_irq);
		sys_en <= 1'b0;
		settle(1);
		check("ca irq off", 0, ca_irq);
		sys_en <= 1'b1;
		pop_all(4);
		// Routing table, one Y-first case
		for (int i = 0; i < 4; i++) begin
			y_first <= (i == 2);
			base = nbr;
			pkt(4, dx[i], dy[i], 7'h02, 32'h0000_0000);
			settle(20);
			if (ep[i] == 0)
				check("ns flits", 3, nbr[0] + nbr[2] - base[0] - base[2]);
			else
				check("xy flits", 3, nbr[ep[i]] - base[ep[i]]);
			check("east flits", ep[i] == 1 ? 3 : 0, nbr[1] - base[1]);
		end
		y_first <= 1'b0;
		// 128-word packet into stalling neighbours
		slow <= 4'hf;
		base = nbr;
		pkt(4, 11'h007, MY, 7'h00, 32'h0000_0000);
		settle(80);
		check("long flits", 129, nbr[1] - base[1]);
		check("overrun", 0, overrun);
		// Two inputs fight for east
		base = nbr;
		fork
			pkt(mswdmx_pkg::P_W, 11'h007, MY, 7'h05, 32'h0000_0000);
			pkt(4, 11'h007, MY, 7'h05, 32'h0000_0000);
		join
		settle(60);
		check("shared flits", 12, nbr[1] - base[1]);
		slow <= 4'h0;
		// Protected east port holds the packet until released
		protect <= 5'h02;
		base = nbr;
		pkt(4, 11'h007, MY, 7'h02, 32'h0000_0000);
		settle(20);
		check("blocked flits", 0, nbr[1] - base[1]);
		check("protect irq", 1, prot_irq);
		protect <= 5'h00;
		settle(20);
		check("released flits", 3, nbr[1] - base[1]);
		finish_test();
	end
endmodule : mswdmx_bench
`default_nettype wire
